//--- include/esi_acc_if.sv
`timescale 1ns/1ns
interface esi_acc_if;
   import esi_pkg::*;
   logic wr;
   logic [GATE_BITS-1:0] gate;
   logic [SAMPLE_BITS-1:0] sample;
   logic clr;
   logic [SUM_BITS-1:0] sum;
   modport ctl (output wr, gate, sample, clr, input sum);
   modport mem (input wr, gate, sample, clr, output sum);
endinterface : esi_acc_if

//--- include/esi_pkg.sv
package esi_pkg;
   // fast clock is 100 MHz
   localparam int CLK_PERIOD_NS = 10;
   localparam int SAMPLE_PERIOD_NS = 100;
   localparam int SAMPLE_DIV = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SAMPLE_BITS = 6;
   localparam int GATES = 254;
   localparam int SUM_BITS = 24;
   localparam int GATE_BITS = 8;
   localparam int WD_TIMEOUT_S = 5;
   localparam longint WD_CYCLES_L = longint'(WD_TIMEOUT_S) * 64'd1000000000 / CLK_PERIOD_NS;
   // laser interval: (sel+1) * base ticks, 8 steps of 51.2 us
   localparam int LASER_BASE_NS = 51200;
   localparam int LASER_BASE_CYC = LASER_BASE_NS / CLK_PERIOD_NS;
   localparam int MON_CHANNELS = 19;
   localparam int MON_ADDR_BITS = 5;
   localparam int MON_RES_BITS = 8;
   localparam int NV_BITS = 1024;
   localparam int NV_ADDR_BITS = 10;
   localparam logic [2:0] GAIN_RST = 3'h0;
   localparam logic [2:0] LSEL_RST = 3'h0;
endpackage : esi_pkg

//--- logic/esi_accum.sv
`timescale 1ns/1ns
module esi_accum
   import esi_pkg::*;
(
   input wire logic mclk_i, // clock
   input wire logic srst_i, // sync reset
   esi_acc_if.mem acc // accumulate port
);
   logic [SAMPLE_BITS-1:0] raw_mem [GATES];
   logic [SUM_BITS-1:0] sum_mem [GATES];
   logic [SUM_BITS-1:0] sum_q;
   logic wr_d; // add runs one cycle behind the store
   logic clr_d;
   logic [GATE_BITS-1:0] gate_d;

   // raw shot store, then hardware add of the stored sample [RULE_02] [RULE_03]
   always_ff @(posedge mclk_i) begin
      wr_d <= srst_i ? 1'b0 : acc.wr;
      clr_d <= acc.clr; // first shot starts its gate sum from zero [RULE_09]
      gate_d <= acc.gate;
      if (acc.wr) begin
         raw_mem[acc.gate] <= acc.sample; // [RULE_02]
      end
      // stored sample joins its gate sum one cycle after the store [RULE_03]
      if (wr_d) begin
         sum_mem[gate_d] <= (clr_d ? '0 : sum_mem[gate_d]) + SUM_BITS'(raw_mem[gate_d]);
      end
      sum_q <= srst_i ? '0 : sum_mem[acc.gate];
   end
   assign acc.sum = sum_q;
endmodule : esi_accum

//--- logic/esi_top.sv
// Functional notes
// [RULE_01] sample 6-bit echo every 100 ns, each sample one 50 ft gate
// [RULE_02] store 254 samples per shot in fast memory
// [RULE_03] hardware adds each sample to its gate sum, written back
// [RULE_04] laser trigger interval chosen by software
// [RULE_05] echo gain held in logic, set by software
// [RULE_06] 19-channel monitor adc, serial address in, result out
// [RULE_07] watchdog resets processor after 5 s without activity
// [RULE_08] 1 kbit nonvolatile parameter store, processor read and write; code holds it in plain registers with no retention
// [RULE_09] gate sums cleared at start of each integration sequence
`timescale 1ns/1ns
module esi_top
   import esi_pkg::*;
#(
   parameter longint WD_CYCLES = WD_CYCLES_L // shorten in simulation
) (
   input wire logic mclk_i, // 100 MHz clock
   input wire logic srst_i, // sync reset, high
   input wire logic [SAMPLE_BITS-1:0] adc_d_i, // flash adc data
   input wire logic [2:0] gain_sel_i, // processor gain setting
   input wire logic gain_ld_i, // load gain
   input wire logic [2:0] laser_sel_i, // interval select
   input wire logic seq_start_i, // begin integration sequence
   input wire logic [7:0] shots_i, // shots per sequence
   input wire logic cpu_alive_i, // processor activity pin
   input wire logic mon_sclk_i, // monitor serial clock pin
   input wire logic mon_sdi_i, // monitor address bit pin
   input wire logic [MON_RES_BITS-1:0] mon_conv_i, // conversion value
   input wire logic nv_we_i, // nv write strobe
   input wire logic [NV_ADDR_BITS-1:0] nv_addr_i, // nv bit address
   input wire logic nv_d_i, // nv write bit
   output logic nv_q_o, // nv read bit
   output logic [2:0] gain_o, // amplifier gain
   output logic laser_trg_o, // laser trigger pulse
   output logic adc_clk_o, // sample strobe to adc
   output logic seq_busy_o, // sequence running
   output logic [SUM_BITS-1:0] sum_o, // gate sum readback
   output logic [MON_ADDR_BITS-1:0] mon_ch_o, // monitor channel
   output logic mon_sdo_o, // monitor result bit
   output logic cpu_rst_o // processor reset
);
   // sequencer: idle, laser interval, range sampling
   typedef enum logic [1:0] {S_IDLE, S_WAIT, S_SAMPLE} esi_st_t;
   typedef struct packed {
      // shot sequencer
      esi_st_t st;
      logic [2:0] gain;
      logic [2:0] lsel;
      logic [19:0] lcnt;
      logic [3:0] dcnt;
      logic [GATE_BITS-1:0] gate;
      logic [7:0] shots;
      logic first;
      logic trg;
      logic aclk;
      logic busy;
      // watchdog
      logic [35:0] wd;
      logic wrst;
      // pin synchronisers, stage 1 in bit 0
      logic [2:0] sck_s;
      logic [1:0] sdi_s;
      logic [1:0] alv_s;
      logic alv_d;
      logic [SAMPLE_BITS-1:0][1:0] ad_s;
      // monitor serial port
      logic [MON_ADDR_BITS-1:0] ch;
      logic [MON_RES_BITS-1:0] sh;
      logic [2:0] bcnt;
      logic sdo;
   } esi_state_t;
   // sequencer, watchdog, synchroniser and monitor state in one register, next value built below
   esi_state_t s_reg, s_next;
   // parameter store bits; power-up contents undefined
   logic [NV_BITS-1:0] nv_mem;
   logic nv_q_reg;
   logic [SAMPLE_BITS-1:0] adc_sync;
   esi_acc_if acc ();

   // sample and sum memories sit in their own module, behind the interface
   esi_accum u_accum (.mclk_i(mclk_i), .srst_i(srst_i), .acc(acc));

   // two-flop sync of adc bits, read only from second stage [RULE_01]
   // bits are synced one by one; the word is coherent only because the
   // strobe leads the write by several cycles
   for (genvar b = 0; b < SAMPLE_BITS; b++) begin : g_adc_sync
      assign adc_sync[b] = s_reg.ad_s[b][1];
   end

   // write into sample and sum memories on each sample tick
   // the first shot of a sequence replaces instead of adding
   always_comb begin
      acc.wr = (s_reg.st == S_SAMPLE) && (s_reg.dcnt == 4'h0); // [RULE_02]
      acc.gate = s_reg.gate;
      acc.sample = adc_sync;
      acc.clr = s_reg.first; // [RULE_09]
   end

   always_comb begin
      s_next = s_reg;
      s_next.trg = 1'b0;
      // adc pins: stage 1 takes the pin, stage 2 takes stage 1
      for (int b = 0; b < SAMPLE_BITS; b++) begin
         s_next.ad_s[b] = {s_reg.ad_s[b][0], adc_d_i[b]};
      end
      // activity and monitor pins, same two-stage scheme
      s_next.alv_s = {s_reg.alv_s[0], cpu_alive_i};
      s_next.sck_s = {s_reg.sck_s[1:0], mon_sclk_i};
      s_next.sdi_s = {s_reg.sdi_s[0], mon_sdi_i};
      s_next.alv_d = s_reg.alv_s[1];
      // gain latch held for the amplifier [RULE_05]
      // a load lands on the next edge, even in the middle of a shot
      if (gain_ld_i) begin
         s_next.gain = gain_sel_i;
      end

      // shot sequencer
      unique case (s_reg.st)
         S_IDLE: begin
            s_next.busy = 1'b0;
            // zero shots counts as no request; starts while busy are not seen here
            if (seq_start_i && shots_i != 8'h0) begin
               s_next.first = 1'b1; // [RULE_09]
               s_next.shots = shots_i;
               s_next.lsel = laser_sel_i; // [RULE_04]
               s_next.busy = 1'b1;
               s_next.lcnt = 20'h0;
               s_next.st = S_WAIT;
            end
         end
         S_WAIT: begin
            // interval is (sel+1) base steps, set by software [RULE_04]
            // latched select, so a change mid-wait cannot cut an interval short
            s_next.lcnt = s_reg.lcnt + 20'h1;
            if (s_reg.lcnt >= 20'((32'(s_reg.lsel) + 1) * LASER_BASE_CYC - 1)) begin
               s_next.trg = 1'b1; // [RULE_04]
               s_next.gate = '0;
               s_next.dcnt = 4'(SAMPLE_DIV - 1);
               s_next.st = S_SAMPLE;
            end
         end
         S_SAMPLE: begin
            // one sample per 100 ns, one gate each [RULE_01]
            s_next.dcnt = (s_reg.dcnt == 4'h0) ? 4'(SAMPLE_DIV - 1) : s_reg.dcnt - 4'h1;
            // strobe leads the write by five cycles so the synced word has settled
            s_next.aclk = (s_reg.dcnt == 4'h6); // [RULE_01]
            if (s_reg.dcnt == 4'h0) begin
               if (s_reg.gate == 8'(GATES - 1)) begin
                  // last gate: the next shot waits a full interval from here
                  s_next.first = 1'b0;
                  s_next.shots = s_reg.shots - 8'h1;
                  s_next.lsel = laser_sel_i; // [RULE_04]
                  s_next.lcnt = 20'h0;
                  s_next.st = (s_reg.shots == 8'h1) ? S_IDLE : S_WAIT;
               end else begin
                  // next gate, one 50 ft step further out
                  s_next.gate = s_reg.gate + 8'h1; // [RULE_02]
               end
            end
         end
      endcase

      // watchdog: rising activity edge restarts count [RULE_07]
      // activity in the timeout cycle wins, since it arrived in time;
      // once set, the reset ends only with fresh activity on the pin or with srst_i
      if (s_reg.alv_s[1] && !s_reg.alv_d) begin
         s_next.wd = '0;
         s_next.wrst = 1'b0;
      end else if (s_reg.wd >= 36'(WD_CYCLES - 1)) begin
         s_next.wrst = 1'b1; // held until activity returns [RULE_07]
         s_next.wd = '0;
      end else begin
         s_next.wd = s_reg.wd + 36'h1;
      end

      // monitor serial: address shifted in, result shifted out, msb first [RULE_06]
      if (s_reg.sck_s[1] && !s_reg.sck_s[2]) begin
         s_next.ch = {s_reg.ch[MON_ADDR_BITS-2:0], s_reg.sdi_s[1]};
         s_next.sdo = s_reg.sh[MON_RES_BITS-1];
         s_next.sh = {s_reg.sh[MON_RES_BITS-2:0], 1'b0};
         s_next.bcnt = s_reg.bcnt + 3'h1;
         if (s_reg.bcnt == 3'h7) begin
            // channels 19 and above convert as zero [RULE_06]
            // the range test uses the address with its last bit shifted in;
            // mon_conv_i must already hold the result for that channel
            s_next.sh = (s_next.ch < 5'(MON_CHANNELS)) ? mon_conv_i : '0;
         end
      end
   end

   // state register
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         // clear all, then the idle state and the default settings
         s_reg <= '0;
         s_reg.st <= S_IDLE;
         s_reg.gain <= GAIN_RST;
         s_reg.lsel <= LSEL_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // 1 kbit parameter store; power-up contents are software's concern [RULE_08]
   // one bit per access keeps the store small; a byte takes eight accesses
   always_ff @(posedge mclk_i) begin
      if (nv_we_i) begin
         nv_mem[nv_addr_i] <= nv_d_i; // [RULE_08]
      end
      nv_q_reg <= srst_i ? 1'b0 : nv_mem[nv_addr_i];
   end

   // every output is a register or a register field
   assign nv_q_o = nv_q_reg;
   assign gain_o = s_reg.gain;
   assign laser_trg_o = s_reg.trg;
   assign adc_clk_o = s_reg.aclk;
   assign seq_busy_o = s_reg.busy;
   assign sum_o = acc.sum;
   assign mon_ch_o = s_reg.ch;
   assign mon_sdo_o = s_reg.sdo;
   assign cpu_rst_o = s_reg.wrst;
endmodule : esi_top

//--- verif/esi_checker.sv
`timescale 1ns/1ns
module esi_checker
   import esi_pkg::*;
(
   input wire logic mclk_i, // clock
   input wire logic srst_i, // reset
   input wire logic [2:0] gain_sel_i, // gain
   input wire logic gain_ld_i, // load
   input wire logic seq_start_i, // start
   input wire logic [7:0] shots_i, // shots
   input wire logic cpu_alive_i, // activity
   input wire logic nv_we_i, // write
   input wire logic [NV_ADDR_BITS-1:0] nv_addr_i, // address
   input wire logic nv_d_i, // data
   input wire logic nv_q_o, // read
   input wire logic [2:0] gain_o, // gain
   input wire logic laser_trg_o, // trigger
   input wire logic adc_clk_o, // strobe
   input wire logic seq_busy_o, // busy
   input wire logic cpu_rst_o // cpu reset
);
   localparam int MIN_GAP = LASER_BASE_CYC - 2;
   logic [15:0] gap_reg; // cycles since last trigger
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   // saturating, so long waits between triggers cannot wrap; held at zero while idle
   always_ff @(posedge mclk_i) begin
      if (srst_i || laser_trg_o || !seq_busy_o) gap_reg <= 16'h0;
      else if (gap_reg != 16'hffff) gap_reg <= gap_reg + 16'h1;
   end
   trig_pulse_a: assert property (laser_trg_o |=> !laser_trg_o)
      else $error("trigger longer than one cycle");
   trig_space_a: assert property (laser_trg_o |-> int'(gap_reg) >= MIN_GAP)
      else $error("trigger before interval elapsed");
   idle_quiet_a: assert property (!seq_busy_o |-> !laser_trg_o)
      else $error("trigger while idle");
   strobe_space_a: assert property (adc_clk_o |=> !adc_clk_o [*8])
      else $error("sample strobes too close");
   gate_sample_a: assert property (laser_trg_o |-> ##[0:10] adc_clk_o)
      else $error("no sample after trigger");
   gain_load_a: assert property (gain_ld_i |=> gain_o == $past(gain_sel_i))
      else $error("gain not loaded");
   start_take_a: assert property (seq_start_i && !seq_busy_o && shots_i != 8'h0
      |=> seq_busy_o)
      else $error("start not taken");
   wd_cause_a: assert property ($rose(cpu_rst_o) |-> $past(cpu_alive_i, 8) == 1'b0)
      else $error("reset despite activity");
   nv_back_a: assert property (nv_we_i ##1 (!nv_we_i && $stable(nv_addr_i))
      |=> nv_q_o == $past(nv_d_i, 2))
      else $error("store readback wrong");
endmodule : esi_checker
bind esi_top esi_checker u_chk (.mclk_i, .srst_i, .gain_sel_i, .gain_ld_i, .seq_start_i,
   .shots_i, .cpu_alive_i, .nv_we_i, .nv_addr_i, .nv_d_i, .nv_q_o, .gain_o, .laser_trg_o,
   .adc_clk_o, .seq_busy_o, .cpu_rst_o);

//--- verif/esi_echo_model.sv
`timescale 1ns/1ns
// echo receiver stand-in: fixed echo level while a sequence runs
module esi_echo_model
   import esi_pkg::*;
(
   input wire logic mclk_i, // clock
   input wire logic busy_i, // sequence running
   input wire logic [SAMPLE_BITS-1:0] amp_i, // echo level
   output logic [SAMPLE_BITS-1:0] echo_o // converter input
);
   initial echo_o = '0;
   // idle line wanders so a stale level never passes for an echo
   always @(posedge mclk_i) begin
      echo_o <= busy_i ? amp_i : ~echo_o;
   end
endmodule : esi_echo_model

//--- verif/tb.sv
`timescale 1ns/1ns
module tb;
   import esi_pkg::*;
   logic mclk_i, srst_i, gain_ld_i, seq_start_i, cpu_alive_i, mon_sclk_i, mon_sdi_i;
   logic nv_we_i, nv_d_i, nv_q_o, laser_trg_o, adc_clk_o, seq_busy_o, mon_sdo_o, cpu_rst_o;
   logic [2:0] gain_sel_i, laser_sel_i, gain_o;
   logic [7:0] shots_i, mon_conv_i, res;
   logic [NV_ADDR_BITS-1:0] nv_addr_i;
   logic [SAMPLE_BITS-1:0] adc_d_i, amp;
   logic [SUM_BITS-1:0] sum_o;
   logic [MON_ADDR_BITS-1:0] mon_ch_o;
   int miscompares = 0, tests_run = 0, cycles = 0;
   esi_top #(.WD_CYCLES(100)) DUT (.mclk_i, .srst_i, .adc_d_i, .gain_sel_i, .gain_ld_i,
      .laser_sel_i, .seq_start_i, .shots_i, .cpu_alive_i, .mon_sclk_i, .mon_sdi_i,
      .mon_conv_i, .nv_we_i, .nv_addr_i, .nv_d_i, .nv_q_o, .gain_o, .laser_trg_o,
      .adc_clk_o, .seq_busy_o, .sum_o, .mon_ch_o, .mon_sdo_o, .cpu_rst_o);
   esi_echo_model u_echo (.mclk_i, .busy_i(seq_busy_o), .amp_i(amp), .echo_o(adc_d_i));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // hang guard, well above the two sequences of about 50k cycles
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         miscompares++;
         give_verdict();
      end
   end
   task tick(input int n); repeat (n) @(posedge mclk_i); endtask : tick
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task t_gain;
      for (int i = 0; i < 8; i++) begin
         gain_sel_i <= 3'(i);
         gain_ld_i <= 1'b1;
         tick(1);
         gain_ld_i <= 1'b0;
         gain_sel_i <= ~3'(i);
         tick(2);
         #1 chk(gain_o, i);
      end
      $display("gain done");
   endtask : t_gain
   task t_nv;
      for (int i = 0; i < 3; i++) begin
         nv_addr_i <= 10'(i * 511);
         nv_d_i <= i[0] ^ 1'b1;
         nv_we_i <= 1'b1;
         tick(1);
         nv_we_i <= 1'b0;
         tick(1);
      end
      for (int i = 0; i < 3; i++) begin
         nv_addr_i <= 10'(i * 511);
         tick(2);
         #1 chk(nv_q_o, i[0] ^ 1'b1);
      end
      $display("store done");
   endtask : t_nv
   // one serial frame, address msb first, result bits taken after each edge
   task frame(input logic [7:0] a);
      for (int i = 7; i >= 0; i--) begin
         mon_sdi_i <= a[i];
         mon_sclk_i <= 1'b0;
         tick(4);
         mon_sclk_i <= 1'b1;
         tick(4);
         #1 res[i] = mon_sdo_o;
      end
   endtask : frame
   task t_mon;
      mon_conv_i <= 8'ha5;
      frame(8'h12);
      chk(mon_ch_o, 32'h12);
      frame(8'h13);
      chk(res, 32'ha5);
      frame(8'h00);
      chk(res, 32'h0);
      $display("monitor done");
   endtask : t_mon
   task t_wd;
      cpu_alive_i <= 1'b1;
      tick(4);
      cpu_alive_i <= 1'b0;
      tick(60);
      #1 chk(cpu_rst_o, 0);
      tick(60);
      #1 chk(cpu_rst_o, 1);
      cpu_alive_i <= 1'b1;
      tick(8);
      #1 chk(cpu_rst_o, 0);
      cpu_alive_i <= 1'b0;
      $display("watchdog done");
   endtask : t_wd
   // a start during the run must be ignored; sums restart per sequence
   task t_seq(input logic [2:0] sel, input int n, input logic [5:0] a);
      int cnt;
      int trg;
      cnt = 0;
      trg = 1;
      amp <= a;
      laser_sel_i <= sel;
      shots_i <= 8'(n);
      seq_start_i <= 1'b1;
      tick(1);
      seq_start_i <= 1'b0;
      do begin
         tick(1);
         #1 cnt++;
      end while (laser_trg_o !== 1'b1 && cnt < 20000);
      chk(cnt, (sel + 1) * LASER_BASE_CYC);
      seq_start_i <= 1'b1;
      tick(1);
      seq_start_i <= 1'b0;
      do begin
         tick(1);
         #1 cnt++;
         if (laser_trg_o === 1'b1) trg++;
      end while (seq_busy_o === 1'b1 && cnt < 60000);
      chk(trg, n);
      tick(3);
      #1 chk(sum_o, n * a);
      chk(seq_busy_o, 0);
      $display("sequence done");
   endtask : t_seq
   task give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      {srst_i, gain_ld_i, seq_start_i, cpu_alive_i, mon_sclk_i, mon_sdi_i} = 6'h20;
      {nv_we_i, nv_d_i, gain_sel_i, laser_sel_i, shots_i, mon_conv_i} = '0;
      nv_addr_i = '0;
      amp = '0;
      tick(5);
      srst_i <= 1'b0;
      tick(1);
      t_gain();
      t_nv();
      t_mon();
      t_wd();
      t_seq(3'h1, 2, 6'h3f);
      t_seq(3'h0, 3, 6'h15);
      give_verdict();
   end
endmodule : tb
